// ===== mrcs_pkg.sv
// package of constants and types for the mesh radio command block
package mrcs_pkg;
  // command codes presented on cmd_code_in
  typedef enum logic [3:0] {
    MRCS_CMD_NONE,
    MRCS_CMD_APPLY,
    MRCS_CMD_RESTART,
    MRCS_CMD_DEFAULT,
    MRCS_CMD_SAVE,
    MRCS_CMD_SET_SLOT,
    MRCS_CMD_SET_TAG,
    MRCS_CMD_SET_REPEAT,
    MRCS_CMD_SET_POWER,
    MRCS_CMD_SET_RETRY,
    MRCS_CMD_SET_HOPS,
    MRCS_CMD_SET_MESH,
    MRCS_CMD_SET_SLOTS,
    MRCS_CMD_SCAN
  } mrcs_cmd_t;
  // route situations for timeout sizing
  typedef enum logic [1:0] {
    MRCS_ROUTE_KNOWN,
    MRCS_ROUTE_UNKNOWN,
    MRCS_ROUTE_BROKEN
  } mrcs_route_t;
  // clock and timing
  localparam int CLK_MHZ = 200;
  localparam int MS_CYCLES = CLK_MHZ * 1000;
  localparam int RESTART_DELAY_MS = 100;
  localparam int RESTART_CYCLES = RESTART_DELAY_MS * MS_CYCLES;
  localparam int BCAST_SLOT_MS = 18;
  localparam logic [7:0] HOP_MS_R0 = 8'h12;
  localparam logic [7:0] HOP_MS_R1 = 8'h2A;
  localparam logic [7:0] HOP_MS_R2 = 8'h43;
  localparam logic [7:0] HOP_MS_R3 = 8'h63;
  // parameter ranges
  localparam logic [7:0] SLOT_MIN_STD = 8'h0B;
  localparam logic [7:0] SLOT_MAX_STD = 8'h1A;
  localparam logic [7:0] SLOT_MIN_HP = 8'h0C;
  localparam logic [7:0] SLOT_MAX_HP = 8'h17;
  localparam logic [15:0] TAG_MAX = 16'h7FFF;
  localparam logic [3:0] POWER_MAX = 4'h4;
  localparam logic [7:0] HOPS_MIN = 8'h01;
  localparam logic [7:0] HOPS_MAX = 8'h20;
  localparam logic [3:0] MESH_MAX = 4'h7;
  localparam logic [3:0] SLOTS_MIN = 4'h1;
  localparam logic [3:0] SLOTS_MAX = 4'hA;
  localparam logic [7:0] SCAN_MAX_MS = 8'h0C;
  // factory defaults
  localparam logic [7:0] SLOT_RESET = 8'h0C;
  localparam logic [15:0] TAG_RESET = 16'h7FFF;
  localparam logic [3:0] REPEAT_RESET = 4'h3;
  localparam logic [3:0] POWER_RESET = 4'h4;
  localparam logic [3:0] RETRY_RESET = 4'hA;
  localparam logic [7:0] HOPS_RESET = 8'h07;
  localparam logic [3:0] MESH_RESET = 4'h1;
  localparam logic [3:0] SLOTS_RESET = 4'h3;
  // energy report characters
  localparam logic [7:0] CHAR_COMMA = 8'h2C;
  localparam logic [7:0] CHAR_CR = 8'h0D;
endpackage

// ===== mrcs_core.sv
// command interpreter core of the mesh radio block
`timescale 1ns/10ps
module mrcs_core #(
  parameter int RESTART_CNT = mrcs_pkg::RESTART_CYCLES, // restart wait cycles
  parameter int MS_CNT = mrcs_pkg::MS_CYCLES, // cycles per millisecond
  parameter bit HIGH_POWER = 1'b0 // high-power variant select
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire mrcs_pkg::mrcs_cmd_t cmd_code_in,
  input wire logic [15:0] cmd_arg_in,
  input wire mrcs_pkg::mrcs_route_t route_kind_in,
  input wire logic [15:0] peer_tag_in,
  input wire logic [7:0] energy_in,
  output logic resp_ok_out,
  output logic resp_err_out,
  output logic soft_reset_out,
  output logic nv_write_out,
  output logic [7:0] active_slot_out,
  output logic [15:0] active_tag_out,
  output logic [3:0] active_power_out,
  output logic [4:0] bcast_sends_out,
  output logic ack_request_out,
  output logic tag_match_out,
  output logic [31:0] route_timeout_ms_out,
  output logic [2:0] route_phase_out,
  output logic [7:0] scan_chan_out,
  output logic scan_busy_out,
  output logic [7:0] rpt_char_out,
  output logic rpt_valid_out
);
  ////////////////////////////////////////////////////////////////////////
  // settings: pending, active and saved copies
  typedef struct packed {
    logic [7:0] slot;
    logic [15:0] tag;
    logic [3:0] repeat_cnt;
    logic [3:0] power;
    logic [3:0] retry;
    logic [7:0] hops;
    logic [3:0] mesh;
    logic [3:0] slots;
  } mrcs_set_t;
  localparam mrcs_set_t SET_DEFAULT = '{mrcs_pkg::SLOT_RESET, mrcs_pkg::TAG_RESET,
    mrcs_pkg::REPEAT_RESET, mrcs_pkg::POWER_RESET, mrcs_pkg::RETRY_RESET,
    mrcs_pkg::HOPS_RESET, mrcs_pkg::MESH_RESET, mrcs_pkg::SLOTS_RESET};
  localparam int NCHAN = 16; // 802.15.4 channels 11..26
  mrcs_set_t pend_reg, pend_next; // pending values
  mrcs_set_t act_reg, act_next; // values in effect
  mrcs_set_t nv_reg, nv_next; // non-volatile copy
  logic ok_reg, ok_next;
  logic err_reg, err_next;
  logic nvw_reg, nvw_next;
  logic rst_pend_reg, rst_pend_next; // restart countdown running
  logic [31:0] rst_cnt_reg, rst_cnt_next;
  logic srst_reg, srst_next;
  // range check of a set or scan command
  function automatic logic arg_ok(input mrcs_pkg::mrcs_cmd_t c, input logic [15:0] a);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = HIGH_POWER ? mrcs_pkg::SLOT_MIN_HP : mrcs_pkg::SLOT_MIN_STD;
    hi = HIGH_POWER ? mrcs_pkg::SLOT_MAX_HP : mrcs_pkg::SLOT_MAX_STD;
    unique case (c)
      mrcs_pkg::MRCS_CMD_SET_SLOT: arg_ok = a[15:8] == 8'h00 && a[7:0] >= lo && a[7:0] <= hi;
      mrcs_pkg::MRCS_CMD_SET_TAG: arg_ok = a <= mrcs_pkg::TAG_MAX;
      mrcs_pkg::MRCS_CMD_SET_REPEAT: arg_ok = a[15:4] == 12'h000;
      mrcs_pkg::MRCS_CMD_SET_POWER: arg_ok = a[15:4] == 12'h000 && a[3:0] <= mrcs_pkg::POWER_MAX;
      mrcs_pkg::MRCS_CMD_SET_RETRY: arg_ok = a[15:4] == 12'h000;
      mrcs_pkg::MRCS_CMD_SET_HOPS: arg_ok = a[15:8] == 8'h00 && a[7:0] >= mrcs_pkg::HOPS_MIN
        && a[7:0] <= mrcs_pkg::HOPS_MAX;
      mrcs_pkg::MRCS_CMD_SET_MESH: arg_ok = a[15:4] == 12'h000 && a[3:0] <= mrcs_pkg::MESH_MAX;
      mrcs_pkg::MRCS_CMD_SET_SLOTS: arg_ok = a[15:4] == 12'h000 && a[3:0] >= mrcs_pkg::SLOTS_MIN
        && a[3:0] <= mrcs_pkg::SLOTS_MAX;
      mrcs_pkg::MRCS_CMD_SCAN: arg_ok = a <= {8'h00, mrcs_pkg::SCAN_MAX_MS};
      default: arg_ok = 1'b1;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // scan state machine
  typedef enum logic [1:0] {
    MRCS_SCAN_IDLE,
    MRCS_SCAN_RUN,
    MRCS_SCAN_REPORT
  } mrcs_scan_t;
  mrcs_scan_t scan_reg, scan_next;
  logic [7:0] ms_left_reg, ms_left_next; // milliseconds remaining
  logic [31:0] ms_cnt_reg, ms_cnt_next; // cycles within a millisecond
  logic [3:0] chan_reg, chan_next; // channel being scanned
  logic [7:0] peak_reg [NCHAN]; // maximum energy per channel
  logic [7:0] peak_next [NCHAN];
  logic [4:0] rpt_idx_reg, rpt_idx_next; // report position
  logic rpt_comma_reg, rpt_comma_next; // comma due next
  logic [7:0] rch_reg, rch_next;
  logic rvl_reg, rvl_next;
  logic [7:0] schan_reg, schan_next; // channel number on show
  logic busy_reg, busy_next; // scan or report under way
  logic scan_start;
  ////////////////////////////////////////////////////////////////////////
  // command decode and settings next state
  always_comb begin
    pend_next = pend_reg;
    act_next = act_reg;
    nv_next = nv_reg;
    ok_next = 1'b0;
    err_next = 1'b0;
    nvw_next = 1'b0;
    srst_next = 1'b0;
    rst_pend_next = rst_pend_reg;
    rst_cnt_next = rst_cnt_reg;
    scan_start = 1'b0;
    if (rst_pend_reg) begin
      // countdown to self reset
      if (rst_cnt_reg == 32'h0000_0000) begin
        rst_pend_next = 1'b0;
        srst_next = 1'b1;
      end else begin
        rst_cnt_next = rst_cnt_reg - 32'h0000_0001;
      end
    end
    if (cmd_valid_in && !rst_pend_reg) begin
      if (!arg_ok(cmd_code_in, cmd_arg_in)) begin
        err_next = 1'b1;
      end else begin
        ok_next = cmd_code_in != mrcs_pkg::MRCS_CMD_NONE;
        err_next = cmd_code_in == mrcs_pkg::MRCS_CMD_NONE;
        unique case (cmd_code_in)
          mrcs_pkg::MRCS_CMD_APPLY: act_next = pend_reg;
          mrcs_pkg::MRCS_CMD_RESTART: begin
            rst_pend_next = 1'b1;
            rst_cnt_next = 32'(RESTART_CNT - 1);
          end
          mrcs_pkg::MRCS_CMD_DEFAULT: pend_next = SET_DEFAULT;
          mrcs_pkg::MRCS_CMD_SAVE: begin
            nv_next = pend_reg;
            nvw_next = 1'b1;
          end
          mrcs_pkg::MRCS_CMD_SET_SLOT: pend_next.slot = cmd_arg_in[7:0];
          mrcs_pkg::MRCS_CMD_SET_TAG: pend_next.tag = cmd_arg_in;
          mrcs_pkg::MRCS_CMD_SET_REPEAT: pend_next.repeat_cnt = cmd_arg_in[3:0];
          mrcs_pkg::MRCS_CMD_SET_POWER: pend_next.power = cmd_arg_in[3:0];
          mrcs_pkg::MRCS_CMD_SET_RETRY: pend_next.retry = cmd_arg_in[3:0];
          mrcs_pkg::MRCS_CMD_SET_HOPS: pend_next.hops = cmd_arg_in[7:0];
          mrcs_pkg::MRCS_CMD_SET_MESH: pend_next.mesh = cmd_arg_in[3:0];
          mrcs_pkg::MRCS_CMD_SET_SLOTS: pend_next.slots = cmd_arg_in[3:0];
          mrcs_pkg::MRCS_CMD_SCAN: begin
            ok_next = 1'b0; // answered by the report instead
            scan_start = scan_reg == MRCS_SCAN_IDLE;
            err_next = scan_reg != MRCS_SCAN_IDLE;
          end
          default: ;
        endcase
      end
    end
    if (srst_next) begin
      // restart reloads saved values
      pend_next = nv_reg;
      act_next = nv_reg;
    end
  end
  // settings registers
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pend_reg <= SET_DEFAULT;
      act_reg <= SET_DEFAULT;
      nv_reg <= SET_DEFAULT;
      ok_reg <= 1'b0;
      err_reg <= 1'b0;
      nvw_reg <= 1'b0;
      srst_reg <= 1'b0;
      rst_pend_reg <= 1'b0;
      rst_cnt_reg <= 32'h0000_0000;
    end else begin
      pend_reg <= pend_next;
      act_reg <= act_next;
      nv_reg <= nv_next;
      ok_reg <= ok_next;
      err_reg <= err_next;
      nvw_reg <= nvw_next;
      srst_reg <= srst_next;
      rst_pend_reg <= rst_pend_next;
      rst_cnt_reg <= rst_cnt_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // derived link values and timeout estimate
  logic [7:0] hop_ms; // one hop delay
  logic [31:0] known_ms, bcast_ms, tmo_next;
  logic [2:0] phase_next;
  logic [4:0] sends_next;
  always_comb begin
    unique case (act_reg.retry)
      4'h0: hop_ms = mrcs_pkg::HOP_MS_R0;
      4'h1: hop_ms = mrcs_pkg::HOP_MS_R1;
      4'h2: hop_ms = mrcs_pkg::HOP_MS_R2;
      default: hop_ms = mrcs_pkg::HOP_MS_R3;
    endcase
    known_ms = 32'(2 * act_reg.hops * act_reg.mesh * hop_ms);
    bcast_ms = 32'(act_reg.slots * act_reg.hops * (act_reg.repeat_cnt + 5'h01)
      * mrcs_pkg::BCAST_SLOT_MS);
    sends_next = 5'(act_reg.repeat_cnt) + 5'h01;
    unique case (route_kind_in)
      mrcs_pkg::MRCS_ROUTE_KNOWN: begin
        tmo_next = known_ms;
        phase_next = 3'b001; // send only
      end
      mrcs_pkg::MRCS_ROUTE_UNKNOWN: begin
        tmo_next = bcast_ms + 32'(act_reg.hops) * 32'(hop_ms) + known_ms;
        phase_next = 3'b011; // discover, then send
      end
      default: begin
        tmo_next = bcast_ms + 32'(act_reg.hops) * 32'(hop_ms) + 32'(2) * known_ms;
        phase_next = 3'b111; // old route, discover, new route
      end
    endcase
  end
  logic [31:0] tmo_reg;
  logic [2:0] phase_reg;
  logic [4:0] sends_reg;
  logic ack_reg, match_reg;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tmo_reg <= 32'h0000_0000;
      phase_reg <= 3'b000;
      sends_reg <= 5'h00;
      ack_reg <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      tmo_reg <= tmo_next;
      phase_reg <= phase_next;
      sends_reg <= sends_next;
      ack_reg <= act_reg.retry != 4'h0;
      match_reg <= peer_tag_in == act_reg.tag;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // energy scan and report next state
  always_comb begin
    scan_next = scan_reg;
    ms_left_next = ms_left_reg;
    ms_cnt_next = ms_cnt_reg;
    chan_next = chan_reg;
    peak_next = peak_reg;
    rpt_idx_next = rpt_idx_reg;
    rpt_comma_next = rpt_comma_reg;
    rch_next = 8'h00;
    rvl_next = 1'b0;
    unique case (scan_reg)
      MRCS_SCAN_IDLE: if (scan_start) begin
        scan_next = MRCS_SCAN_RUN;
        ms_left_next = cmd_arg_in[7:0];
        ms_cnt_next = 32'h0000_0000;
        chan_next = 4'h0;
        for (int i = 0; i < NCHAN; i++) peak_next[i] = 8'hFF; // weakest possible
      end
      MRCS_SCAN_RUN: begin
        // energy is in -dBm units, so smaller is stronger
        if (energy_in < peak_reg[chan_reg]) peak_next[chan_reg] = energy_in;
        chan_next = chan_reg + 4'h1;
        if (ms_left_reg == 8'h00) begin
          scan_next = MRCS_SCAN_REPORT;
          rpt_idx_next = 5'h00;
          rpt_comma_next = 1'b0;
        end else if (ms_cnt_reg == 32'(MS_CNT - 1)) begin
          ms_cnt_next = 32'h0000_0000;
          ms_left_next = ms_left_reg - 8'h01;
        end else begin
          ms_cnt_next = ms_cnt_reg + 32'h0000_0001;
        end
      end
      MRCS_SCAN_REPORT: begin
        rvl_next = 1'b1;
        if (rpt_idx_reg == 5'(NCHAN)) begin
          rch_next = mrcs_pkg::CHAR_CR;
          scan_next = MRCS_SCAN_IDLE;
        end else if (rpt_comma_reg) begin
          rch_next = mrcs_pkg::CHAR_COMMA;
          rpt_comma_next = 1'b0;
          rpt_idx_next = rpt_idx_reg + 5'h01;
        end else begin
          rch_next = peak_reg[rpt_idx_reg[3:0]];
          rpt_comma_next = 1'b1;
        end
      end
      default: scan_next = MRCS_SCAN_IDLE;
    endcase
    // channel number and busy flag kept in flops
    schan_next = 8'h0B + {4'h0, chan_next};
    busy_next = scan_next != MRCS_SCAN_IDLE;
  end
  // scan registers
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      scan_reg <= MRCS_SCAN_IDLE;
      ms_left_reg <= 8'h00;
      ms_cnt_reg <= 32'h0000_0000;
      chan_reg <= 4'h0;
      for (int i = 0; i < NCHAN; i++) peak_reg[i] <= 8'hFF;
      rpt_idx_reg <= 5'h00;
      rpt_comma_reg <= 1'b0;
      rch_reg <= 8'h00;
      rvl_reg <= 1'b0;
      schan_reg <= 8'h0B;
      busy_reg <= 1'b0;
    end else begin
      scan_reg <= scan_next;
      ms_left_reg <= ms_left_next;
      ms_cnt_reg <= ms_cnt_next;
      chan_reg <= chan_next;
      peak_reg <= peak_next;
      rpt_idx_reg <= rpt_idx_next;
      rpt_comma_reg <= rpt_comma_next;
      rch_reg <= rch_next;
      rvl_reg <= rvl_next;
      schan_reg <= schan_next;
      busy_reg <= busy_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign resp_ok_out = ok_reg;
  assign resp_err_out = err_reg;
  assign soft_reset_out = srst_reg;
  assign nv_write_out = nvw_reg;
  assign active_slot_out = act_reg.slot;
  assign active_tag_out = act_reg.tag;
  assign active_power_out = act_reg.power;
  assign bcast_sends_out = sends_reg;
  assign ack_request_out = ack_reg;
  assign tag_match_out = match_reg;
  assign route_timeout_ms_out = tmo_reg;
  assign route_phase_out = phase_reg;
  assign scan_chan_out = schan_reg;
  assign scan_busy_out = busy_reg;
  assign rpt_char_out = rch_reg;
  assign rpt_valid_out = rvl_reg;
endmodule

// ===== mrcs_core_asserts.sv
// port checker for the mesh radio command core
`timescale 1ns/10ps
module mrcs_checker #(
  parameter int RESTART_CNT = 20 // restart wait cycles
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire mrcs_pkg::mrcs_cmd_t cmd_code_in,
  input wire logic [15:0] cmd_arg_in,
  input wire logic [15:0] peer_tag_in,
  input wire logic resp_ok_out,
  input wire logic resp_err_out,
  input wire logic soft_reset_out,
  input wire logic [7:0] active_slot_out,
  input wire logic [15:0] active_tag_out,
  input wire logic [3:0] active_power_out,
  input wire logic tag_match_out,
  input wire logic scan_busy_out,
  input wire logic [7:0] rpt_char_out,
  input wire logic rpt_valid_out
);
  localparam int RST_DLY = RESTART_CNT; // edges from ok to self reset
  logic quiet_reg; // restart countdown running
  logic quiet_next;
  logic take; // command the core will act on
  assign take = cmd_valid_in && !quiet_reg;
  ////////////////////////////////////////////////////////////////
  // countdown tracker next value
  always_comb begin
    quiet_next = quiet_reg;
    if (soft_reset_out) begin
      quiet_next = 1'b0;
    end else if (take && cmd_code_in == mrcs_pkg::MRCS_CMD_RESTART) begin
      quiet_next = 1'b1;
    end
  end
  // countdown tracker register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      quiet_reg <= 1'b0;
    end else begin
      quiet_reg <= quiet_next;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  restart_ok_delay_a: assert property (take && cmd_code_in == mrcs_pkg::MRCS_CMD_RESTART
    |-> ##1 resp_ok_out ##RST_DLY soft_reset_out) else $error("restart timing wrong");
  early_reset_a: assert property (soft_reset_out |-> quiet_reg)
    else $error("self reset without restart");
  bad_tag_err_a: assert property (take && cmd_code_in == mrcs_pkg::MRCS_CMD_SET_TAG
    && cmd_arg_in > mrcs_pkg::TAG_MAX |=> resp_err_out && !resp_ok_out) else $error("tag not refused");
  bad_power_err_a: assert property (take && cmd_code_in == mrcs_pkg::MRCS_CMD_SET_POWER
    && cmd_arg_in > 16'h0004 |=> resp_err_out && !resp_ok_out) else $error("power not refused");
  scan_busy_err_a: assert property (take && cmd_code_in == mrcs_pkg::MRCS_CMD_SCAN
    && scan_busy_out |=> resp_err_out) else $error("scan while busy taken");
  none_code_err_a: assert property (take && cmd_code_in == mrcs_pkg::MRCS_CMD_NONE |=> resp_err_out)
    else $error("empty command not refused");
  reset_defaults_a: assert property ($rose(rst_n_in) |-> active_slot_out == 8'h0C
    && active_tag_out == 16'h7FFF && active_power_out == 4'h4) else $error("defaults wrong");
  tag_match_a: assert property ($past(rst_n_in) |-> tag_match_out
    == ($past(peer_tag_in) == $past(active_tag_out))) else $error("tag match wrong");
  report_end_a: assert property ($fell(scan_busy_out) |-> rpt_valid_out
    && rpt_char_out == mrcs_pkg::CHAR_CR) else $error("report not ended by CR");
  power_range_a: assert property (active_power_out <= mrcs_pkg::POWER_MAX)
    else $error("power code out of range");
  cover property (soft_reset_out);
  cover property ($fell(scan_busy_out));
  cover property (resp_err_out);
endmodule
bind mrcs_core mrcs_checker #(.RESTART_CNT(RESTART_CNT)) i_chk (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in),
  .cmd_arg_in(cmd_arg_in), .peer_tag_in(peer_tag_in), .resp_ok_out(resp_ok_out),
  .resp_err_out(resp_err_out), .soft_reset_out(soft_reset_out), .active_slot_out(active_slot_out),
  .active_tag_out(active_tag_out), .active_power_out(active_power_out), .tag_match_out(tag_match_out),
  .scan_busy_out(scan_busy_out), .rpt_char_out(rpt_char_out), .rpt_valid_out(rpt_valid_out));

// ===== mrcs_host.sv
// host model that issues commands to the core
`timescale 1ns/10ps
module mrcs_host (
  input wire logic clk_in,
  input wire logic resp_ok_in,
  input wire logic resp_err_in,
  output logic cmd_valid_out,
  output mrcs_pkg::mrcs_cmd_t cmd_code_out,
  output logic [15:0] cmd_arg_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_code_out = mrcs_pkg::MRCS_CMD_NONE;
    cmd_arg_out = 16'h0000;
  end
  // one pulse, then sample the answer just after the next edge
  task automatic send(input mrcs_pkg::mrcs_cmd_t code, input logic [15:0] arg, output logic [1:0] rsp);
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_code_out <= code;
    cmd_arg_out <= arg;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_arg_out <= ~arg; // stale argument never looks valid
    #1;
    rsp = {resp_err_in, resp_ok_in};
  endtask
endmodule

// ===== testbench.sv
// self-checking testbench of the mesh radio command core
`timescale 1ns/10ps
module testbench;
  localparam int RCNT = 20; // shortened restart wait
  localparam int MCNT = 4; // shortened millisecond
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cmd_valid, ok, err, srst, nvw, ack, tmatch, busy, rvalid;
  mrcs_pkg::mrcs_cmd_t cmd_code;
  logic [15:0] cmd_arg, tag;
  mrcs_pkg::mrcs_route_t route_kind = mrcs_pkg::MRCS_ROUTE_KNOWN;
  logic [15:0] peer_tag = 16'h0000;
  logic [7:0] energy = 8'h00, slot, schan, rchar;
  logic [3:0] pwr;
  logic [4:0] bsends;
  logic [31:0] tmo;
  logic [2:0] phase;
  logic [1:0] rsp;
  int err_count = 0, num_checks = 0, cyc = 0, t0;
  int p[8], a[8], s[8]; // pending, active, saved model
  int dflt[8] = '{12, 32767, 3, 4, 10, 7, 1, 3};
  int lo[8] = '{11, 0, 0, 0, 0, 1, 0, 1};
  int hi[8] = '{26, 32767, 15, 4, 15, 32, 7, 10};
  logic [7:0] q[$], got[$]; // expected and seen report bytes
  always #2.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) cyc <= cyc + 1;
  mrcs_core #(.RESTART_CNT(RCNT), .MS_CNT(MCNT), .HIGH_POWER(1'b0)) i_dut (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code), .cmd_arg_in(cmd_arg),
    .route_kind_in(route_kind), .peer_tag_in(peer_tag), .energy_in(energy), .resp_ok_out(ok),
    .resp_err_out(err), .soft_reset_out(srst), .nv_write_out(nvw), .active_slot_out(slot),
    .active_tag_out(tag), .active_power_out(pwr), .bcast_sends_out(bsends), .ack_request_out(ack),
    .tag_match_out(tmatch), .route_timeout_ms_out(tmo), .route_phase_out(phase),
    .scan_chan_out(schan), .scan_busy_out(busy), .rpt_char_out(rchar), .rpt_valid_out(rvalid));
  mrcs_host i_host (.clk_in(sys_clk_in), .resp_ok_in(ok), .resp_err_in(err),
    .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code), .cmd_arg_out(cmd_arg));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  // command with model update and answer compare
  task automatic cmd(input mrcs_pkg::mrcs_cmd_t c, input int v);
    int k;
    logic [1:0] e;
    k = int'(c) - 5;
    e = 2'b01;
    if (c == mrcs_pkg::MRCS_CMD_NONE) e = 2'b10;
    else if (k >= 0 && k < 8) begin
      if (v < lo[k] || v > hi[k]) e = 2'b10;
      else p[k] = v;
    end else if (c == mrcs_pkg::MRCS_CMD_APPLY) a = p;
    else if (c == mrcs_pkg::MRCS_CMD_DEFAULT) p = dflt;
    else if (c == mrcs_pkg::MRCS_CMD_SAVE) s = p;
    else if (c == mrcs_pkg::MRCS_CMD_SCAN) e = v > int'(mrcs_pkg::SCAN_MAX_MS) ? 2'b10 : 2'b00;
    i_host.send(c, v[15:0], rsp);
    chk(rsp, e);
    chk(nvw, c == mrcs_pkg::MRCS_CMD_SAVE);
  endtask
  task automatic chk_act();
    tick(1);
    chk(slot, a[0]);
    chk(tag, a[1]);
    chk(bsends, a[2] + 1);
    chk(pwr, a[3]);
    chk(ack, a[4] != 0);
  endtask
  // timeouts and phases for all three route situations
  task automatic chk_route();
    int h, hop, kn, bc;
    h = a[5];
    hop = a[4] == 0 ? 18 : a[4] == 1 ? 42 : a[4] == 2 ? 67 : 99;
    kn = 2 * h * a[6] * hop;
    bc = a[7] * h * (a[2] + 1) * 18;
    for (int r = 0; r < 3; r++) begin
      route_kind <= mrcs_pkg::mrcs_route_t'(r);
      tick(2);
      chk(tmo, r == 0 ? kn : bc + h * hop + kn * r);
      chk(phase, r == 0 ? 1 : r == 1 ? 3 : 7);
    end
  endtask
  // energy scan with report compare
  task automatic scan(input int ms);
    logic [7:0] ev;
    ev = 8'($urandom_range(1, 254));
    energy <= ev;
    q.delete();
    got.delete();
    for (int i = 0; i < 16; i++) begin
      q.push_back(i < ms * MCNT + 1 ? ev : 8'hFF);
      q.push_back(mrcs_pkg::CHAR_COMMA);
    end
    q.push_back(mrcs_pkg::CHAR_CR);
    i_host.send(mrcs_pkg::MRCS_CMD_SCAN, ms[15:0], rsp);
    chk(rsp, 0);
    chk(schan, 8'h0B);
    if (ms > 4) begin
      i_host.send(mrcs_pkg::MRCS_CMD_SCAN, 16'h0000, rsp);
      chk(rsp, 2'b10);
    end
    for (int i = 0; i < 300 && got.size() < 33; i++) begin
      tick(1);
      if (rvalid) got.push_back(rchar);
    end
    if (got.size() < 33) begin
      err_count++;
      print_verdict();
    end
    foreach (q[i]) chk(got[i], q[i]);
    tick(1);
    chk(busy, 0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(94));
    a = dflt;
    p = dflt;
    s = dflt;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    chk_act();
    chk_route();
    cmd(mrcs_pkg::MRCS_CMD_NONE, 0);
    for (int k = 0; k < 8; k++) begin
      cmd(mrcs_pkg::mrcs_cmd_t'(k + 5), hi[k] + 1);
      if (lo[k] > 0) cmd(mrcs_pkg::mrcs_cmd_t'(k + 5), lo[k] - 1);
    end
    for (int it = 0; it < 6; it++) begin
      for (int k = 0; k < 8; k++) begin
        cmd(mrcs_pkg::mrcs_cmd_t'(k + 5), (k == 4 && it < 4) ? it : $urandom_range(lo[k], hi[k]));
      end
      cmd(mrcs_pkg::MRCS_CMD_APPLY, 0);
      chk_act();
      chk_route();
      peer_tag <= a[1][15:0];
      tick(2);
      chk(tmatch, 1);
      peer_tag <= a[1][15:0] ^ 16'h0001;
      tick(2);
      chk(tmatch, 0);
    end
    cmd(mrcs_pkg::MRCS_CMD_SET_TAG, $urandom_range(0, 32767));
    cmd(mrcs_pkg::MRCS_CMD_SAVE, 0);
    cmd(mrcs_pkg::MRCS_CMD_DEFAULT, 0);
    cmd(mrcs_pkg::MRCS_CMD_APPLY, 0);
    chk_act();
    cmd(mrcs_pkg::MRCS_CMD_RESTART, 0);
    t0 = cyc;
    i_host.send(mrcs_pkg::MRCS_CMD_SET_TAG, 16'h0000, rsp);
    chk(rsp, 0);
    for (int i = 0; i < 100 && !srst; i++) tick(1);
    chk(cyc - t0, RCNT);
    a = s;
    p = s;
    chk_act();
    scan(0);
    scan(1);
    scan(12);
    cmd(mrcs_pkg::MRCS_CMD_SCAN, 13);
    print_verdict();
  end
endmodule
